// ---- pbc_pkg.sv ----
// Shared constants and types for the pixel blit coprocessor
package pbc_pkg;
	localparam int PBC_AW = 20; // Pixel address width
	localparam int PBC_CW = 12; // Coordinate and extent width
	localparam int PBC_FIFO_DEPTH = 16; // Write buffer depth in words
	// Address update functions
	typedef enum logic [2:0] {
		F_BLIT = 3'h0, F_INV = 3'h1, F_FILL = 3'h2, F_WLINE = 3'h3,
		F_RLINE = 3'h4, F_WDS = 3'h5, F_RDS = 3'h6
	} pbc_func_t;
	// Per-pixel sequence, fetch states in order
	typedef enum logic [2:0] {
		S_IDLE = 3'h0, S_SRC = 3'h1, S_PAT = 3'h2, S_MSK = 3'h3,
		S_DST = 3'h4, S_MIX = 3'h5, S_STEP = 3'h6
	} pbc_state_t;
	localparam logic [1:0] MSK_OFF = 2'h0; // Mask ignored
	localparam logic [1:0] MSK_BND = 2'h1; // Boundary scissor only
	localparam logic [1:0] MSK_ON = 2'h2; // Contents plus boundary
	localparam logic [1:0] SRC_MAP = 2'h0; // Source from a map
	localparam logic [1:0] SRC_FG = 2'h1; // Fixed foreground colour
	localparam logic [1:0] PAT_FG = 2'h0; // Pattern forced foreground
	localparam logic [1:0] PAT_MAP = 2'h1; // Pattern from a map
	localparam logic [1:0] PAT_SRC = 2'h2; // Pattern from source != 0
	localparam logic [1:0] DM_FIRST = 2'h1; // First pixel null
	localparam logic [1:0] DM_LAST = 2'h2; // Last pixel null
	localparam logic [1:0] DM_OUTL = 2'h3; // Area outline
	localparam logic [1:0] ST_NONE = 2'h0; // Step codes
	localparam logic [1:0] ST_INC = 2'h1;
	localparam logic [1:0] ST_DEC = 2'h3;
	localparam logic [4:0] MIX_MAX = 5'h10; // Arithmetic mixes
	localparam logic [4:0] MIX_MIN = 5'h11;
	localparam logic [4:0] MIX_ADDS = 5'h12;
	localparam logic [4:0] MIX_SUBD = 5'h13;
	localparam logic [4:0] MIX_SUBS = 5'h14;
	localparam logic [4:0] MIX_AVG = 5'h15;
endpackage

// ---- pbc_fifo.sv ----
// Write buffer between the pixel engine and the memory write port
`timescale 1ns/1ps
module pbc_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic in_valid_i,
	output logic in_ready_o,
	input wire logic [WIDTH-1:0] in_data_i,
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [WIDTH-1:0] out_data_o,
	output logic empty_o
);
	localparam int PW = $clog2(DEPTH);
	if (DEPTH < 2 || (1 << PW) != DEPTH) $error("FIFO depth must be a power of two");
	logic [WIDTH-1:0] mem [DEPTH]; // Storage, no reset needed
	logic [PW-1:0] wp; // Write index
	logic [PW-1:0] rp; // Read index
	logic [PW:0] cnt; // Occupancy
	logic push;
	logic pop;
	assign in_ready_o = cnt != (PW+1)'(DEPTH);
	assign out_valid_o = cnt != '0;
	assign empty_o = cnt == '0;
	assign out_data_o = mem[rp];
	assign push = in_valid_i && in_ready_o;
	assign pop = out_valid_o && out_ready_i;
	// Data store
	always_ff @(posedge clk_i) begin
		if (push) begin
			mem[wp] <= in_data_i;
		end
	end
	// Pointers and count
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			wp <= '0;
			rp <= '0;
			cnt <= '0;
		end else begin
			wp <= push ? wp + PW'(1) : wp;
			rp <= pop ? rp + PW'(1) : rp;
			cnt <= cnt + (PW+1)'(push) - (PW+1)'(pop);
		end
	end
endmodule

// ---- pbc_engine.sv ----
// Pixel blit coprocessor drawing engine
`timescale 1ns/1ps
module pbc_engine import pbc_pkg::*; #(
	parameter int AW = PBC_AW,
	parameter int CW = PBC_CW,
	parameter int DEPTH = PBC_FIFO_DEPTH
) (
	input wire logic REF_CLK_I,
	input wire logic RST_N_I,
	input wire logic START_I,
	input wire logic [2:0] FUNC_I,
	input wire logic [1:0] SRC_SEL_I,
	input wire logic [1:0] PAT_SEL_I,
	input wire logic [1:0] SRC_MAP_I,
	input wire logic [1:0] PAT_MAP_I,
	input wire logic [1:0] DST_MAP_I,
	input wire logic [1:0] MSK_MODE_I,
	input wire logic [1:0] DRAW_MODE_I,
	input wire logic [4:0] FG_MIX_I,
	input wire logic [4:0] BG_MIX_I,
	input wire logic [7:0] FG_COLOR_I,
	input wire logic [7:0] BG_COLOR_I,
	input wire logic CMP_EN_I,
	input wire logic CMP_SEL_I,
	input wire logic [7:0] CMP_VAL_I,
	input wire logic [7:0] PLANE_MASK_I,
	input wire logic [3*AW-1:0] MAP_BASE_I,
	input wire logic [3*CW-1:0] MAP_W_I,
	input wire logic [3*CW-1:0] MAP_H_I,
	input wire logic [5:0] MAP_BPP_I,
	input wire logic [AW-1:0] MSK_BASE_I,
	input wire logic [CW-1:0] MSK_W_I,
	input wire logic [CW-1:0] MSK_H_I,
	input wire logic [CW-1:0] MSK_OFFX_I,
	input wire logic [CW-1:0] MSK_OFFY_I,
	input wire logic [CW-1:0] SRC_X_I,
	input wire logic [CW-1:0] SRC_Y_I,
	input wire logic [CW-1:0] PAT_X_I,
	input wire logic [CW-1:0] PAT_Y_I,
	input wire logic [CW-1:0] DST_X_I,
	input wire logic [CW-1:0] DST_Y_I,
	input wire logic [CW-1:0] CNT_W_I,
	input wire logic [CW-1:0] CNT_H_I,
	input wire logic [2:0] LINE_OCT_I,
	input wire logic [CW+1:0] LINE_ERR_I,
	input wire logic [CW+1:0] LINE_K1_I,
	input wire logic [CW+1:0] LINE_K2_I,
	input wire logic [3:0] STEP_DIR_I,
	input wire logic RD_ACK_I,
	input wire logic [7:0] RD_DATA_I,
	input wire logic WR_RDY_I,
	output logic BUSY_O,
	output logic DONE_O,
	output logic RD_REQ_O,
	output logic [AW-1:0] RD_ADDR_O,
	output logic WR_VLD_O,
	output logic [AW-1:0] WR_ADDR_O,
	output logic [7:0] WR_DATA_O
);
	if (CW < 2 || AW < CW) $error("Address narrower than coordinates");

	// Depth code to pixel value mask
	function automatic logic [7:0] dmask(input logic [1:0] b);
		case (b)
			2'h0: return 8'h01;
			2'h1: return 8'h03;
			2'h2: return 8'h0f;
			default: return 8'hff;
		endcase
	endfunction

	// One step of a coordinate, optionally wrapping inside ext
	function automatic logic [CW-1:0] step(input logic [CW-1:0] v, input logic [1:0] st,
			input logic [CW-1:0] ext, input logic wrap);
		if (st == ST_INC) return (wrap && v >= ext - CW'(1)) ? '0 : v + CW'(1);
		if (st == ST_DEC) return (wrap && (v == '0 || v >= ext)) ? ext - CW'(1) : v - CW'(1);
		return v;
	endfunction

	// Linear pixel address of x,y in a map
	function automatic logic [AW-1:0] paddr(input logic [AW-1:0] b, input logic [CW-1:0] w,
			input logic [CW-1:0] x, input logic [CW-1:0] y);
		return AW'(b + AW'(y) * AW'(w) + AW'(x));
	endfunction

	// Foreground or background mix of source and destination
	function automatic logic [7:0] mix(input logic [4:0] op, input logic [7:0] s,
			input logic [7:0] d, input logic [7:0] m);
		logic [8:0] t;
		t = 9'h000;
		if (op < MIX_MAX) begin
			// Truth table in op[3:0], indexed by source and destination bit
			t = {1'b0, ({8{op[3]}} & s & d) | ({8{op[2]}} & s & ~d)
				| ({8{op[1]}} & ~s & d) | ({8{op[0]}} & ~s & ~d)};
		end else begin
			case (op)
				MIX_MAX: t = {1'b0, (s > d) ? s : d};
				MIX_MIN: t = {1'b0, (s < d) ? s : d};
				MIX_ADDS: begin
					t = {1'b0, s} + {1'b0, d};
					t = (t > {1'b0, m}) ? {1'b0, m} : t;
				end
				MIX_SUBD: t = {1'b0, (d > s) ? d - s : 8'h00};
				MIX_SUBS: t = {1'b0, (s > d) ? s - d : 8'h00};
				MIX_AVG: t = ({1'b0, s} + {1'b0, d}) >> 1;
				default: t = {1'b0, d}; // Undefined codes keep the pixel
			endcase
		end
		return t[7:0] & m;
	endfunction

	pbc_state_t state; // Per-pixel sequence
	logic [AW-1:0] mb [4]; // Map fields by map number
	logic [CW-1:0] mw [4];
	logic [CW-1:0] mh [4];
	logic [1:0] md [4];
	logic [CW-1:0] sx, sy, px, py, dx, dy; // Map pointers
	logic [CW-1:0] cnt_x, cnt_y; // Progress counters
	logic signed [CW+1:0] err; // Line decision variable
	logic moved_y; // Last step changed y
	logic [7:0] src_pix, dst_pix; // Fetched pixels
	logic pat_bit, msk_bit;
	logic [1:0] st_x, st_y;
	logic blit_fn, rd_fn, row_end, last, in_dst, in_mask;
	logic need, pat_eff, msk_ok, cmp_ok, draw_ok, wr_ok, fifo_rdy, fifo_empty;
	logic [AW-1:0] fa;
	logic [CW-1:0] mx, my;
	logic [7:0] d_dm, mixv, wdata;

	// Three general maps; number 3 reads as an empty map
	for (genvar g = 0; g < 3; g++) begin : g_map
		assign mb[g] = MAP_BASE_I[g*AW +: AW];
		assign mw[g] = MAP_W_I[g*CW +: CW];
		assign mh[g] = MAP_H_I[g*CW +: CW];
		assign md[g] = MAP_BPP_I[g*2 +: 2];
	end
	assign mb[3] = '0;
	assign mw[3] = '0;
	assign mh[3] = '0;
	assign md[3] = '0;

	// Pointer stepping decisions
	always_comb begin
		blit_fn = FUNC_I == F_BLIT || FUNC_I == F_INV || FUNC_I == F_FILL;
		rd_fn = FUNC_I == F_RLINE || FUNC_I == F_RDS;
		row_end = cnt_x == CNT_W_I - CW'(1);
		st_x = ST_NONE;
		st_y = ST_NONE;
		if (blit_fn) begin
			// Inverted blit walks right to left, bottom to top
			st_x = (FUNC_I == F_INV) ? ST_DEC : ST_INC;
			st_y = row_end ? st_x : ST_NONE;
		end else if (FUNC_I == F_WLINE || FUNC_I == F_RLINE) begin
			// Major axis always moves, minor when err is not negative
			if (!LINE_OCT_I[2] || err >= 0) st_x = LINE_OCT_I[1] ? ST_DEC : ST_INC;
			if (LINE_OCT_I[2] || err >= 0) st_y = LINE_OCT_I[0] ? ST_DEC : ST_INC;
		end else begin
			st_x = STEP_DIR_I[1:0];
			st_y = STEP_DIR_I[3:2];
		end
		last = blit_fn ? (row_end && cnt_y == CNT_H_I - CW'(1)) : row_end;
	end

	// Fetch address, scissors and write decision for the current pixel
	always_comb begin
		d_dm = dmask(md[DST_MAP_I]);
		mx = dx - MSK_OFFX_I;
		my = dy - MSK_OFFY_I;
		in_dst = dx < mw[DST_MAP_I] && dy < mh[DST_MAP_I];
		in_mask = dx >= MSK_OFFX_I && dy >= MSK_OFFY_I && mx < MSK_W_I && my < MSK_H_I;
		case (state)
			S_SRC: begin
				need = SRC_SEL_I == SRC_MAP;
				fa = paddr(mb[SRC_MAP_I], mw[SRC_MAP_I], sx, sy);
			end
			S_PAT: begin
				need = PAT_SEL_I == PAT_MAP;
				fa = paddr(mb[PAT_MAP_I], mw[PAT_MAP_I], px, py);
			end
			S_MSK: begin
				need = MSK_MODE_I == MSK_ON && in_mask;
				fa = paddr(MSK_BASE_I, MSK_W_I, mx, my);
			end
			default: begin
				need = in_dst;
				fa = paddr(mb[DST_MAP_I], mw[DST_MAP_I], dx, dy);
			end
		endcase
		pat_eff = (PAT_SEL_I == PAT_MAP) ? pat_bit : (PAT_SEL_I == PAT_SRC) ? |src_pix : 1'b1;
		// Mask bit set means the window is open at this pixel
		msk_ok = (MSK_MODE_I == MSK_ON) ? (in_mask && msk_bit) :
			(MSK_MODE_I == MSK_BND) ? in_mask : 1'b1;
		cmp_ok = !CMP_EN_I || ((dst_pix == (CMP_VAL_I & d_dm)) == CMP_SEL_I);
		draw_ok = 1'b1;
		if (!blit_fn) begin
			case (DRAW_MODE_I)
				DM_FIRST: draw_ok = cnt_x != '0;
				DM_LAST: draw_ok = !row_end;
				DM_OUTL: draw_ok = cnt_x == '0 || moved_y;
				default: draw_ok = 1'b1;
			endcase
		end
		mixv = mix(pat_eff ? FG_MIX_I : BG_MIX_I, src_pix, dst_pix, d_dm);
		wdata = ((mixv & PLANE_MASK_I) | (dst_pix & ~PLANE_MASK_I)) & d_dm;
		wr_ok = !rd_fn && in_dst && msk_ok && cmp_ok && draw_ok;
	end

	// Pixel sequence, memory reads and completion
	always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			state <= S_IDLE;
			BUSY_O <= 1'b0;
			DONE_O <= 1'b0;
			RD_REQ_O <= 1'b0;
			RD_ADDR_O <= '0;
			src_pix <= 8'h00;
			dst_pix <= 8'h00;
			pat_bit <= 1'b0;
			msk_bit <= 1'b0;
		end else begin
			DONE_O <= 1'b0;
			case (state)
				S_IDLE: if (START_I) begin
					// Start is taken only here, so a busy engine ignores it
					state <= S_SRC;
					BUSY_O <= 1'b1;
				end
				S_SRC, S_PAT, S_MSK, S_DST: begin
					if (!need) begin
						if (state == S_SRC) src_pix <= (SRC_SEL_I == SRC_FG) ? FG_COLOR_I : BG_COLOR_I;
						state <= pbc_state_t'(state + 3'h1);
					end else if (!RD_REQ_O) begin
						// Destination read waits for buffered writes to drain
						if (state != S_DST || fifo_empty) begin
							RD_REQ_O <= 1'b1;
							RD_ADDR_O <= fa;
						end
					end else if (RD_ACK_I) begin
						RD_REQ_O <= 1'b0;
						if (state == S_SRC) src_pix <= RD_DATA_I & dmask(md[SRC_MAP_I]);
						if (state == S_PAT) pat_bit <= RD_DATA_I[0];
						if (state == S_MSK) msk_bit <= RD_DATA_I[0];
						if (state == S_DST) dst_pix <= RD_DATA_I & d_dm;
						state <= pbc_state_t'(state + 3'h1);
					end
				end
				S_MIX: if (!wr_ok || fifo_rdy) state <= S_STEP;
				default: begin
					if (last) begin
						state <= S_IDLE;
						BUSY_O <= 1'b0;
						DONE_O <= 1'b1;
					end else begin
						state <= S_SRC;
					end
				end
			endcase
		end
	end

	// Pointer, counter and line error updates
	always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			{sx, sy, px, py, dx, dy, cnt_x, cnt_y} <= '0;
			err <= '0;
			moved_y <= 1'b0;
		end else if (state == S_IDLE && START_I) begin
			{sx, sy, px, py} <= {SRC_X_I, SRC_Y_I, PAT_X_I, PAT_Y_I};
			{dx, dy, cnt_x, cnt_y} <= {DST_X_I, DST_Y_I, {CW{1'b0}}, {CW{1'b0}}};
			err <= LINE_ERR_I;
			moved_y <= 1'b0;
		end else if (state == S_STEP) begin
			moved_y <= st_y != ST_NONE;
			err <= err + ((err >= 0) ? LINE_K2_I : LINE_K1_I);
			if (blit_fn && row_end) begin
				// New row: x pointers return to their start columns
				{sx, px, dx} <= {SRC_X_I, PAT_X_I, DST_X_I};
				cnt_x <= '0;
				cnt_y <= cnt_y + CW'(1);
			end else begin
				sx <= step(sx, st_x, mw[SRC_MAP_I], 1'b1);
				px <= step(px, st_x, mw[PAT_MAP_I], 1'b1);
				dx <= step(dx, st_x, mw[DST_MAP_I], 1'b0);
				cnt_x <= cnt_x + CW'(1);
			end
			sy <= step(sy, st_y, mh[SRC_MAP_I], 1'b1);
			py <= step(py, st_y, mh[PAT_MAP_I], 1'b1);
			dy <= step(dy, st_y, mh[DST_MAP_I], 1'b0);
		end
	end

	// Write buffer toward pixel memory
	pbc_fifo #(.WIDTH(AW + 8), .DEPTH(DEPTH)) u_wbuf (
		.clk_i(REF_CLK_I),
		.rst_n_i(RST_N_I),
		.in_valid_i(state == S_MIX && wr_ok),
		.in_ready_o(fifo_rdy),
		.in_data_i({fa, wdata}),
		.out_valid_o(WR_VLD_O),
		.out_ready_i(WR_RDY_I),
		.out_data_o({WR_ADDR_O, WR_DATA_O}),
		.empty_o(fifo_empty)
	);

	// Checks on the pixel sequence
	default clocking cb @(posedge REF_CLK_I); endclocking
	default disable iff (!RST_N_I);
	sequence s_last_step;
		state == S_STEP && last;
	endsequence
	sequence s_req_wait;
		RD_REQ_O && !RD_ACK_I;
	endsequence
	a_start_busy: assert property (state == S_IDLE && START_I |=> BUSY_O && state == S_SRC)
		else $error("start not taken");
	a_done_pulse: assert property (s_last_step |=> DONE_O && !BUSY_O ##1 !DONE_O)
		else $error("completion not signalled");
	a_busy_ignore: assert property (BUSY_O && START_I && state != S_STEP |=> cnt_x == $past(cnt_x) && cnt_y == $past(cnt_y))
		else $error("start while busy restarted the operation");
	a_req_hold: assert property (s_req_wait |=> RD_REQ_O && $stable(RD_ADDR_O))
		else $error("read request dropped");
	a_dst_scissor: assert property (state == S_MIX && wr_ok |-> in_dst)
		else $error("write outside destination");
	a_mask_guard: assert property (state == S_MIX && wr_ok && MSK_MODE_I != MSK_OFF |-> in_mask)
		else $error("write outside mask");
	a_cmp_guard: assert property (state == S_MIX && wr_ok && CMP_EN_I
			|-> (dst_pix == (CMP_VAL_I & d_dm)) == CMP_SEL_I)
		else $error("compare not honoured");
	a_plane_mask: assert property (state == S_MIX && wr_ok |-> ((wdata ^ dst_pix) & ~PLANE_MASK_I) == 8'h00)
		else $error("protected plane changed");
	a_read_nowr: assert property (state == S_MIX && rd_fn |-> !wr_ok)
		else $error("read function wrote");
	a_src_wrap: assert property (state == S_STEP && sx < mw[SRC_MAP_I] |=> sx < mw[SRC_MAP_I])
		else $error("source pointer escaped");
	a_first_null: assert property (state == S_MIX && wr_ok && !blit_fn && DRAW_MODE_I == DM_FIRST
			|-> cnt_x != '0)
		else $error("first pixel drawn");
endmodule

// ---- pbc_mem.sv ----
// Pixel memory model on the far side of the engine's read and write ports
`timescale 1ns/1ps
module pbc_mem (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic rd_req_i,
	input wire logic [19:0] rd_addr_i,
	input wire logic [3:0] lat_i,
	input wire logic stall_i,
	input wire logic wr_vld_i,
	input wire logic [19:0] wr_addr_i,
	input wire logic [7:0] wr_data_i,
	output logic rd_ack_o,
	output logic [7:0] rd_data_o,
	output logic wr_rdy_o
);
	logic [7:0] mem [0:1023]; // Pixel store, low ten address bits
	logic [3:0] wait_cnt; // Cycles the open read has waited
	int n_wr = 0; // Writes accepted so far
	// Ready is a plain level so the bench can stall the buffer
	assign wr_rdy_o = !stall_i;
	// Answer after lat_i cycles; data toggles outside the ack cycle
	// so a stale sample never looks like a good pixel
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			wait_cnt <= 4'h0;
			rd_ack_o <= 1'b0;
			rd_data_o <= 8'h5a;
		end else if (rd_req_i && !rd_ack_o && wait_cnt >= lat_i) begin
			rd_ack_o <= 1'b1;
			rd_data_o <= mem[rd_addr_i[9:0]];
			wait_cnt <= 4'h0;
		end else begin
			// Idle, waiting, or the cycle after an ack
			wait_cnt <= (rd_req_i && !rd_ack_o) ? wait_cnt + 4'h1 : 4'h0;
			rd_ack_o <= 1'b0;
			rd_data_o <= ~rd_data_o;
		end
	end
	// Store accepted words; plain always since the bench preloads too
	always @(posedge clk_i) begin
		if (wr_vld_i && wr_rdy_o) begin
			mem[wr_addr_i[9:0]] <= wr_data_i;
			n_wr <= n_wr + 1;
		end
	end
endmodule

// ---- testbench.sv ----
// Self-checking bench for the pixel blit coprocessor engine
`timescale 1ns/1ps
module testbench;
	import pbc_pkg::*;
	logic clk = 1'b0, rst_n = 1'b0, start = 1'b0, cen = 1'b0, csel = 1'b0, stall = 1'b0;
	logic [2:0] func = 3'h0, oct = 3'h0;
	logic [1:0] ssel = 2'h1, psel = 2'h0, mmode = 2'h0, dmode = 2'h0, dmap = 2'h1;
	logic [4:0] fgm = 5'h0c, bgm = 5'h0c;
	logic [7:0] fgc = 8'h0, bgc = 8'h0, cval = 8'h0, pm = 8'hff;
	logic [59:0] base = {20'h00200, 20'h00100, 20'h00000};
	logic [35:0] mw = {3{12'h004}}, mh = {3{12'h004}};
	logic [5:0] bpp = 6'h3f;
	logic [11:0] mox = 12'h1, moy = 12'h0, sx = 12'h0, sy = 12'h0, dx = 12'h0, dy = 12'h0;
	logic [11:0] cw = 12'h1, ch = 12'h1;
	logic [13:0] lerr = 14'h0; // Line terms, held at zero by these tests
	logic [3:0] sdir = 4'h0, lat = 4'h0;
	logic busy, done, rreq, ack, wvld, wrdy;
	logic [19:0] raddr, waddr;
	logic [7:0] rdata, wdata;
	int bad_count = 0, n_checks = 0;
	// Free-running 250 MHz clock
	always #2 clk = ~clk;
	pbc_engine i_pbc_engine (
		.REF_CLK_I(clk), .RST_N_I(rst_n), .START_I(start), .FUNC_I(func), .SRC_SEL_I(ssel),
		.PAT_SEL_I(psel), .SRC_MAP_I(2'h0), .PAT_MAP_I(2'h2), .DST_MAP_I(dmap),
		.MSK_MODE_I(mmode), .DRAW_MODE_I(dmode), .FG_MIX_I(fgm), .BG_MIX_I(bgm),
		.FG_COLOR_I(fgc), .BG_COLOR_I(bgc), .CMP_EN_I(cen), .CMP_SEL_I(csel),
		.CMP_VAL_I(cval), .PLANE_MASK_I(pm), .MAP_BASE_I(base), .MAP_W_I(mw), .MAP_H_I(mh),
		.MAP_BPP_I(bpp), .MSK_BASE_I(20'h00300), .MSK_W_I(12'h2), .MSK_H_I(12'h1),
		.MSK_OFFX_I(mox), .MSK_OFFY_I(moy), .SRC_X_I(sx), .SRC_Y_I(sy), .PAT_X_I(sx),
		.PAT_Y_I(sy), .DST_X_I(dx), .DST_Y_I(dy), .CNT_W_I(cw), .CNT_H_I(ch),
		.LINE_OCT_I(oct), .LINE_ERR_I(lerr), .LINE_K1_I(lerr), .LINE_K2_I(lerr),
		.STEP_DIR_I(sdir), .RD_ACK_I(ack), .RD_DATA_I(rdata), .WR_RDY_I(wrdy),
		.BUSY_O(busy), .DONE_O(done), .RD_REQ_O(rreq), .RD_ADDR_O(raddr),
		.WR_VLD_O(wvld), .WR_ADDR_O(waddr), .WR_DATA_O(wdata)
	);
	pbc_mem i_pbc_mem (
		.clk_i(clk), .rst_n_i(rst_n), .rd_req_i(rreq), .rd_addr_i(raddr), .lat_i(lat),
		.stall_i(stall), .wr_vld_i(wvld), .wr_addr_i(waddr), .wr_data_i(wdata),
		.rd_ack_o(ack), .rd_data_o(rdata), .wr_rdy_o(wrdy)
	);
	// Compare and count
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic ld(input int a, input logic [7:0] v);
		i_pbc_mem.mem[a] = v;
	endtask
	function automatic logic [7:0] rd(input int a);
		return i_pbc_mem.mem[a];
	endfunction
	// Defaults for one operation; all loaded before any start
	task automatic cfg(input logic [2:0] f, input logic [11:0] w, input logic [4:0] fm);
		@(posedge clk);
		func <= f;
		cw <= w;
		ch <= 12'h1;
		fgm <= fm;
		bgm <= fm;
		fgc <= 8'h3c;
		ssel <= SRC_FG;
		psel <= PAT_FG;
		mmode <= MSK_OFF;
		dmode <= 2'h0;
		cen <= 1'b0;
		pm <= 8'hff;
		{sx, sy, dx, dy, moy} <= 60'h0;
		mw <= {3{12'h004}};
		bpp <= 6'h3f;
		sdir <= 4'h0;
		for (int a = 0; a < 32; a++) ld(32'h100 + a, 8'h00);
	endtask
	// Start, optionally hold start while busy, wait for done and drain
	task automatic run(input int again, input int nexp);
		int n0;
		int i;
		n0 = i_pbc_mem.n_wr;
		i = 0;
		@(posedge clk);
		start <= 1'b1;
		repeat (1 + again) @(posedge clk);
		start <= 1'b0;
		#1;
		chk(busy, 1'b1);
		while (done !== 1'b1 && i < 4000) begin
			@(posedge clk);
			#1;
			i++;
		end
		chk(busy, 1'b0);
		while (wvld !== 1'b0 && i < 4000) begin
			@(posedge clk);
			#1;
			i++;
		end
		chk(i < 4000, 1'b1);
		if (nexp >= 0) chk(i_pbc_mem.n_wr - n0, nexp);
	endtask
	// Normal, area-fill and inverted blits of a 2x2 block
	task automatic t_blit();
		logic [2:0] fs [3] = '{F_BLIT, F_FILL, F_INV};
		for (int k = 0; k < 3; k++) begin
			cfg(fs[k], 12'h2, 5'h0c);
			@(posedge clk);
			ch <= 12'h2;
			{dx, dy} <= {12'h1, 12'h1};
			run(k == 0 ? 2 : 0, 4);
			for (int i = 0; i < 16; i++) begin
				// Inverted blit runs from (1,1) leftward and upward
				chk(rd(32'h100 + i), (k == 2 ? (i == 0 || i == 1 || i == 4 || i == 5)
					: (i == 5 || i == 6 || i == 9 || i == 10)) ? 8'h3c : 8'h00);
			end
		end
		$display("test blit done");
	endtask
	// Pattern from source over a two-wide wrapping source map
	task automatic t_wrap();
		cfg(F_BLIT, 12'h4, 5'h0c);
		@(posedge clk);
		ssel <= SRC_MAP;
		psel <= PAT_SRC;
		bgm <= 5'h0f;
		sy <= 12'h1;
		mw <= {12'h4, 12'h4, 12'h2};
		ld(2, 8'h00);
		ld(3, 8'h22);
		run(0, 4);
		for (int i = 0; i < 4; i++) chk(rd(32'h100 + i), i[0] ? 8'h22 : 8'hff);
		// Pattern from map two, pointers shared with the source
		@(posedge clk);
		psel <= PAT_MAP;
		ld(32'h204, 8'h01);
		ld(32'h205, 8'h00);
		ld(32'h206, 8'h00);
		ld(32'h207, 8'h01);
		run(0, 4);
		chk({rd(32'h100), rd(32'h101), rd(32'h102), rd(32'h103)}, 32'h00ffff22);
		$display("test wrap done");
	endtask
	// Colour compare both senses, plane mask keeps upper bits
	task automatic t_cmp();
		cfg(F_BLIT, 12'h2, 5'h0c);
		@(posedge clk);
		ssel <= 2'h2;
		bgc <= 8'h3c;
		{cen, cval, pm} <= {1'b1, 8'h55, 8'h0f};
		ld(32'h100, 8'h55);
		ld(32'h101, 8'h66);
		run(0, -1);
		chk(rd(32'h100), 8'h55);
		chk(rd(32'h101), 8'h6c);
		@(posedge clk);
		csel <= 1'b1;
		run(0, -1);
		chk(rd(32'h100), 8'h5c);
		chk(rd(32'h101), 8'h6c);
		$display("test compare done");
	endtask
	// Mask off, boundary only, contents; mask kept inside destination
	task automatic t_mask();
		logic [3:0] e [3] = '{4'hf, 4'h6, 4'h2};
		for (int m = 0; m < 3; m++) begin
			cfg(F_BLIT, 12'h4, 5'h0c);
			@(posedge clk);
			mmode <= m[1:0];
			{dy, moy} <= {12'h1, 12'h1};
			ld(32'h300, 8'h01);
			ld(32'h301, 8'h00);
			run(0, -1);
			for (int x = 0; x < 4; x++) chk(rd(32'h104 + x), e[m][x] ? 8'h3c : 8'h00);
		end
		$display("test mask done");
	endtask
	// Every logic and arithmetic mix on one pixel
	task automatic t_mix();
		logic [7:0] ar [6] = '{8'h9c, 8'h8a, 8'hff, 8'h00, 8'h12, 8'h93};
		logic [7:0] r;
		for (int k = 0; k < 22; k++) begin
			cfg(F_BLIT, 12'h1, k[4:0]);
			@(posedge clk);
			fgc <= 8'h9c;
			ld(32'h100, 8'h8a);
			run(0, -1);
			for (int b = 0; b < 8; b++) r[b] = k[{fgc[b], 1'b0} | {1'b0, rd(32'h100) === 8'h0}];
			for (int b = 0; b < 8; b++) r[b] = k[{8'h9c >> b & 8'h1, 1'b0} | (8'h8a >> b & 8'h1)];
			chk(rd(32'h100), k < 16 ? r : ar[k - 16]);
		end
		$display("test mix done");
	endtask
	// Destination depths of 1, 2, 4 and 8 bits
	task automatic t_depth();
		for (int d = 0; d < 4; d++) begin
			cfg(F_BLIT, 12'h1, 5'h0c);
			@(posedge clk);
			bpp <= {2'h3, d[1:0], 2'h3};
			fgc <= 8'h3d;
			run(0, 1);
			chk(rd(32'h100), 8'h3d & ((9'h1 << (1 << d)) - 9'h1));
		end
		$display("test depth done");
	endtask
	// Draw and step in each drawing mode, then a read-only pass
	task automatic t_step();
		logic [2:0] e [4] = '{3'h7, 3'h6, 3'h3, 3'h1};
		for (int m = 0; m < 5; m++) begin
			cfg(m < 4 ? F_WDS : F_RDS, 12'h3, 5'h0c);
			@(posedge clk);
			sdir <= 4'h1;
			dmode <= m[1:0];
			run(0, m < 4 ? -1 : 0);
			for (int x = 0; x < 3; x++) chk(rd(32'h100 + x), m < 4 && e[m][x] ? 8'h3c : 8'h00);
		end
		// Diagonal line: zero error terms step both axes each pixel
		cfg(F_WLINE, 12'h3, 5'h0c);
		run(0, 3);
		chk({rd(32'h100), rd(32'h105), rd(32'h10a)}, 24'h3c3c3c);
		$display("test step done");
	endtask
	// Out-of-map destination pixels skipped
	task automatic t_clip();
		cfg(F_BLIT, 12'h4, 5'h0c);
		@(posedge clk);
		dx <= 12'h2;
		run(0, 2);
		chk({rd(32'h102), rd(32'h103), rd(32'h104)}, 24'h3c3c00);
		// Empty map as destination: nothing read, nothing written
		@(posedge clk);
		dmap <= 2'h3;
		run(0, 0);
		chk(rd(32'h100), 8'h00);
		@(posedge clk);
		dmap <= 2'h1;
		$display("test clip done");
	endtask
	// Writes stalled while slow reads wait on the buffer to drain
	task automatic t_fifo();
		cfg(F_BLIT, 12'h14, 5'h0c);
		@(posedge clk);
		mw <= {12'h4, 12'h14, 12'h4};
		stall <= 1'b1;
		lat <= 4'h4;
		fork
			begin
				repeat (300) @(posedge clk);
				stall <= 1'b0;
				#1;
				chk(busy, 1'b1);
			end
			run(0, 20);
		join
		for (int i = 0; i < 21; i++) chk(rd(32'h100 + i), i < 20 ? 8'h3c : 8'h00);
		lat <= 4'h0;
		$display("test fifo done");
	endtask
	// Verdict and end of run
	task automatic end_sim();
		$display("checks=%0d mismatches=%0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	// Hang guard, far beyond the expected run length
	initial begin
		#80000;
		bad_count++;
		end_sim();
	end
	initial begin
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		t_blit();
		t_wrap();
		t_cmp();
		t_mask();
		t_mix();
		t_depth();
		t_step();
		t_clip();
		t_fifo();
		end_sim();
	end
endmodule
